// *** hdl/hrs_pkg.sv ***
// Constants shared by the hot redundancy supervisor.
package hrs_pkg;
	// Role encoding held in the role register.
	localparam logic [1:0] ROLE_OFF    = 2'h0;
	localparam logic [1:0] ROLE_BACKUP = 2'h1;
	localparam logic [1:0] ROLE_MASTER = 2'h2;
	// Register byte addresses.
	localparam logic [7:0] ADDR_ROLE   = 8'h00;
	localparam logic [7:0] ADDR_CFG    = 8'h04;
	localparam logic [7:0] ADDR_KEY    = 8'h08;
	localparam logic [7:0] ADDR_OPMODE = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	// Configuration word fields: reset mode, local assignment, expansion mapping.
	localparam int CFG_W       = 9;
	localparam int CFG_RSTMODE = 0;
	localparam int CFG_ASN_LO  = 1;
	localparam int CFG_EXP_LO  = 5;
	localparam int FN_RELAY    = 0;
	localparam int FN_HANDOVER = 1;
	localparam int FN_FEEDBACK = 2;
	localparam int FN_INDIC    = 3;
	localparam logic [CFG_W-1:0] CFG_RESET = 9'h000;
	// Super-user key; the value is arbitrary.
	localparam logic [31:0] SU_KEY = 32'h5eca_0001;
	// Timing figures in milliseconds and the clock rate.
	localparam int CLK_HZ      = 100_000_000;
	localparam int CYC_PER_MS  = CLK_HZ / 1000;
	localparam int T_DTR_MS    = 5;
	localparam int T_TX_MS     = 100;
	localparam int T_RXTO_MS   = 250;
	localparam int T_DSRTO_MS  = 25;
	localparam int T_HOLD_MS   = 200;
	localparam int T_BOOTM_MS  = 500;
	localparam int T_BOOTB_MS  = 1000;
	localparam int DTR_CYC     = T_DTR_MS * CYC_PER_MS;
	localparam int TX_CYC      = T_TX_MS * CYC_PER_MS;
	localparam int RXTO_CYC    = T_RXTO_MS * CYC_PER_MS;
	localparam int DSRTO_CYC   = T_DSRTO_MS * CYC_PER_MS;
	localparam int HOLD_CYC    = T_HOLD_MS * CYC_PER_MS;
	localparam int BOOTM_CYC   = T_BOOTM_MS * CYC_PER_MS;
	localparam int BOOTB_CYC   = T_BOOTB_MS * CYC_PER_MS;
	localparam int CNT_W       = 27;
	// Supervisor states.
	typedef enum logic [1:0] {ST_BOOT, ST_STANDBY, ST_ACTIVE} sup_state_t;
endpackage

// *** hdl/hot_redundancy_supervisor.sv ***
// Hot redundancy supervisor: role, handover, relay control and peer data alignment.
//
// Overview of operation
// [RL1] Role register: 0 off, 1 backup, 2 master.
// [RL2] Role writes need super-user key first.
// [RL3] Same role on both units raises alarm.
// [RL4] Same role: both active, backup relay off.
// [RL5] Master sends config, role excluded, to backup.
// [RL6] Copied config carries I/O assignment fields.
// [RL7] Missing mandatory assignment raises configuration alarm.
// [RL8] Functions mapped to expansion count as missing.
// [RL9] Only active backup drives transfer relay.
// [RL10] Assigned indicator shows active role.
// [RL11] Handover acts on rising edge only.
// [RL12] Reset mode: handover only when both off.
// [RL13] Expected feedback: master not active, backup active.
// [RL14] Only backup warns on feedback mismatch.
// [RL15] Only active unit enables CAN transmit.
// [RL16] Virtual inputs exchanged; standby uses peer copy.
// [RL17] New active keeps shared analogue for hold.
// [RL18] New active keeps shared speed for hold.
// [RL19] Standby follows peer excitation command.
// [RL20] DTR toggles, status sent, peer timeouts.
// [RL21] Boot waits standby: 500 or 1000 ms.
// [RL22] Reset to standby, flags cleared.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module hot_redundancy_supervisor #(
	parameter int ANA_W      = 16,
	parameter int SPD_W      = 16,
	parameter int VIRT_W     = 8,
	parameter int DTR_CYCLES = hrs_pkg::DTR_CYC,
	parameter int TX_CYCLES  = hrs_pkg::TX_CYC,
	parameter int RXTO_CYCLES  = hrs_pkg::RXTO_CYC,
	parameter int DSRTO_CYCLES = hrs_pkg::DSRTO_CYC,
	parameter int HOLD_CYCLES  = hrs_pkg::HOLD_CYC,
	parameter int BOOTM_CYCLES = hrs_pkg::BOOTM_CYC,
	parameter int BOOTB_CYCLES = hrs_pkg::BOOTB_CYC
) (
	input  wire logic                      mclk_in,
	input  wire logic                      rst_n_in,
	input  wire logic [7:0]                addr_in,
	input  wire logic [31:0]               wdata_in,
	input  wire logic                      wr_in,
	input  wire logic                      rd_in,
	output logic      [31:0]               rdata_out,
	input  wire logic                      handover_request_in,
	input  wire logic                      transfer_relay_feedback_in,
	input  wire logic                      peer_dsr_in,
	input  wire logic                      peer_msg_valid_in,
	input  wire logic [1:0]                peer_role_in,
	input  wire logic                      peer_active_in,
	input  wire logic                      peer_off_in,
	input  wire logic [hrs_pkg::CFG_W-1:0] peer_cfg_in,
	input  wire logic [ANA_W-1:0]          peer_analog_in,
	input  wire logic [SPD_W-1:0]          peer_speed_in,
	input  wire logic [VIRT_W-1:0]         peer_virt_in,
	input  wire logic                      peer_excite_in,
	input  wire logic [ANA_W-1:0]          local_analog_in,
	input  wire logic [SPD_W-1:0]          local_speed_in,
	input  wire logic [VIRT_W-1:0]         local_virt_in,
	input  wire logic                      local_excite_in,
	output logic                           peer_dtr_out,
	output logic                           msg_send_out,
	output logic      [1:0]                msg_role_out,
	output logic                           msg_active_out,
	output logic                           msg_off_out,
	output logic      [hrs_pkg::CFG_W-1:0] msg_cfg_out,
	output logic      [ANA_W-1:0]          msg_analog_out,
	output logic      [SPD_W-1:0]          msg_speed_out,
	output logic      [VIRT_W-1:0]         msg_virt_out,
	output logic                           msg_excite_out,
	output logic                           transfer_relay_cmd_out,
	output logic                           in_control_indicator_out,
	output logic                           can_tx_en_out,
	output logic                           wrong_config_alarm_out,
	output logic                           relay_failure_warning_out,
	output logic      [ANA_W-1:0]          analog_used_out,
	output logic      [SPD_W-1:0]          speed_used_out,
	output logic      [VIRT_W-1:0]         virt_used_out,
	output logic                           excite_out
);
	import hrs_pkg::*;

	// Parameters the counters cannot serve are refused.
	if (ANA_W < 1 || SPD_W < 1 || VIRT_W < 1 || BOOTB_CYCLES >= (1 << CNT_W)
		|| DTR_CYCLES < 1 || HOLD_CYCLES < 1 || BOOTM_CYCLES < 1) begin : g_bad
		$error("hot_redundancy_supervisor: unsupported parameter value");
	end

	localparam logic [CNT_W-1:0] DTR_LAST = CNT_W'(DTR_CYCLES - 1);
	localparam logic [CNT_W-1:0] TX_LAST  = CNT_W'(TX_CYCLES - 1);
	localparam logic [CNT_W-1:0] RXTO_N   = CNT_W'(RXTO_CYCLES);
	localparam logic [CNT_W-1:0] DSRTO_N  = CNT_W'(DSRTO_CYCLES);
	localparam logic [CNT_W-1:0] HOLD_N   = CNT_W'(HOLD_CYCLES);
	localparam logic [CNT_W-1:0] BOOTM_N  = CNT_W'(BOOTM_CYCLES);
	localparam logic [CNT_W-1:0] BOOTB_N  = CNT_W'(BOOTB_CYCLES);

	typedef struct packed {
		sup_state_t         st;
		logic [1:0]         role;
		logic [CFG_W-1:0]   cfg;
		logic               su_ok;
		logic               local_off;
		logic               ho_prev;
		logic [CNT_W-1:0]   boot_cnt;
		logic [CNT_W-1:0]   dtr_cnt;
		logic [CNT_W-1:0]   tx_cnt;
		logic [CNT_W-1:0]   rx_cnt;
		logic [CNT_W-1:0]   dsr_cnt;
		logic [CNT_W-1:0]   hold_cnt;
		logic               dsr_prev;
		logic               peer_seen;
		logic [1:0]         peer_role;
		logic               peer_active;
		logic               peer_off;
		logic               peer_excite;
		logic [ANA_W-1:0]   sh_analog;
		logic [SPD_W-1:0]   sh_speed;
		logic [VIRT_W-1:0]  sh_virt;
		logic               dtr;
		logic               msg_send;
		logic               relay;
		logic               indic;
		logic               can_tx;
		logic               alarm;
		logic               warn;
		logic [ANA_W-1:0]   ana_used;
		logic [SPD_W-1:0]   spd_used;
		logic [VIRT_W-1:0]  virt_used;
		logic               excite;
		logic [31:0]        rdata;
	} sup_t;

	sup_t s_reg;
	sup_t s_next;

	logic peer_ok;
	logic same_role;
	logic missing;
	logic ho_edge;
	logic ho_allowed;
	logic fb_expected;
	logic active_next;

	// Peer health, configuration checks and handover qualification.
	always_comb begin
		peer_ok = s_reg.peer_seen && (s_reg.rx_cnt < RXTO_N) && (s_reg.dsr_cnt < DSRTO_N); // RL20
		same_role = (s_reg.role != ROLE_OFF) && peer_ok && (s_reg.peer_role == s_reg.role); // RL3
		missing = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (!s_reg.cfg[CFG_ASN_LO+i] || s_reg.cfg[CFG_EXP_LO+i]) begin // RL7 RL8
				missing = 1'b1;
			end
		end
		ho_edge = handover_request_in && !s_reg.ho_prev; // RL11
		ho_allowed = ho_edge && (!s_reg.cfg[CFG_RSTMODE]
			|| (s_reg.local_off && s_reg.peer_off)); // RL12
	end

	// Next state of the whole supervisor.
	always_comb begin
		s_next = s_reg;
		s_next.msg_send = 1'b0;
		s_next.ho_prev = handover_request_in;
		s_next.dsr_prev = peer_dsr_in;
		// Register writes; the role needs the key first.
		if (wr_in) begin
			case (addr_in)
				ADDR_ROLE: begin
					if (s_reg.su_ok && wdata_in[1:0] != 2'h3) begin
						s_next.role = wdata_in[1:0]; // RL1 RL2
					end
				end
				ADDR_CFG: s_next.cfg = wdata_in[CFG_W-1:0];
				ADDR_KEY: s_next.su_ok = (wdata_in == SU_KEY); // RL2
				ADDR_OPMODE: s_next.local_off = wdata_in[0];
				default: s_next.su_ok = s_reg.su_ok;
			endcase
		end
		// Link keep-alive: DTR toggle and periodic status message.
		if (s_reg.dtr_cnt == DTR_LAST) begin
			s_next.dtr_cnt = '0;
			s_next.dtr = !s_reg.dtr; // RL20
		end else begin
			s_next.dtr_cnt = s_reg.dtr_cnt + 1'b1;
		end
		if (s_reg.tx_cnt == TX_LAST) begin
			s_next.tx_cnt = '0;
			s_next.msg_send = (s_reg.role != ROLE_OFF); // RL20
		end else begin
			s_next.tx_cnt = s_reg.tx_cnt + 1'b1;
		end
		// Failure timers restart on each message and each DSR change.
		if (s_reg.rx_cnt != RXTO_N) begin
			s_next.rx_cnt = s_reg.rx_cnt + 1'b1;
		end
		if (s_reg.dsr_cnt != DSRTO_N) begin
			s_next.dsr_cnt = s_reg.dsr_cnt + 1'b1;
		end
		if (peer_dsr_in != s_reg.dsr_prev) begin
			s_next.dsr_cnt = '0; // RL20
		end
		if (peer_msg_valid_in) begin
			s_next.rx_cnt = '0;
			s_next.peer_seen = 1'b1;
			s_next.peer_role = peer_role_in;
			s_next.peer_active = peer_active_in;
			s_next.peer_off = peer_off_in;
			s_next.peer_excite = peer_excite_in; // RL19
			s_next.sh_virt = peer_virt_in; // RL16
			if (s_reg.hold_cnt == '0) begin
				s_next.sh_analog = peer_analog_in; // RL17
				s_next.sh_speed = peer_speed_in; // RL18
			end
			if (s_reg.role == ROLE_BACKUP && peer_role_in == ROLE_MASTER) begin
				s_next.cfg = peer_cfg_in; // RL5 RL6
			end
		end
		if (s_reg.hold_cnt != '0) begin
			s_next.hold_cnt = s_reg.hold_cnt - 1'b1;
		end
		if (s_reg.boot_cnt != '0) begin
			s_next.boot_cnt = s_reg.boot_cnt - 1'b1;
		end
		// Role state machine.
		case (s_reg.st)
			ST_BOOT: begin
				if (s_reg.role == ROLE_OFF || same_role) begin
					s_next.st = ST_ACTIVE; // RL4
				end else if (peer_ok && s_reg.peer_active) begin
					s_next.st = ST_STANDBY; // RL21
				end else if (s_reg.role == ROLE_MASTER && peer_ok) begin
					s_next.st = ST_ACTIVE;
				end else if (s_reg.boot_cnt == '0) begin
					s_next.st = ST_ACTIVE; // RL21
				end
			end
			ST_STANDBY: begin
				if (s_reg.role == ROLE_OFF || same_role) begin
					s_next.st = ST_ACTIVE; // RL4
				end else if (s_reg.role == ROLE_BACKUP && !peer_ok) begin
					s_next.st = ST_ACTIVE;
					s_next.hold_cnt = HOLD_N; // RL17 RL18
				end else if (s_reg.role == ROLE_MASTER && ho_allowed) begin
					s_next.st = ST_ACTIVE;
					s_next.hold_cnt = HOLD_N; // RL11
				end
			end
			ST_ACTIVE: begin
				if (s_reg.role == ROLE_BACKUP && !same_role && ho_allowed) begin
					s_next.st = ST_STANDBY; // RL11 RL12
				end else if (s_reg.role == ROLE_MASTER && !same_role && peer_ok
					&& s_reg.peer_active && s_reg.peer_role == ROLE_BACKUP) begin
					s_next.st = ST_STANDBY;
				end
			end
			default: s_next.st = ST_STANDBY;
		endcase
		// A new role restarts the power-on wait.
		if (s_next.role != s_reg.role) begin
			s_next.st = ST_BOOT;
			s_next.boot_cnt = (s_next.role == ROLE_MASTER) ? BOOTM_N : BOOTB_N; // RL21
		end
		active_next = (s_next.st == ST_ACTIVE);
		// Outputs registered from the next state.
		s_next.alarm = (s_reg.role != ROLE_OFF) && (same_role || missing); // RL3 RL7
		s_next.relay = (s_reg.role == ROLE_BACKUP) && active_next && !same_role; // RL4 RL9
		s_next.indic = (s_reg.role != ROLE_OFF) && active_next
			&& s_reg.cfg[CFG_ASN_LO+FN_INDIC] && !s_reg.cfg[CFG_EXP_LO+FN_INDIC]; // RL10
		s_next.can_tx = active_next; // RL15
		fb_expected = (s_reg.st == ST_ACTIVE); // RL13
		s_next.warn = (s_reg.role == ROLE_BACKUP) && !same_role && (s_reg.st != ST_BOOT)
			&& (s_reg.hold_cnt == '0) && (s_next.role == s_reg.role)
			&& (transfer_relay_feedback_in != fb_expected); // RL13 RL14
		s_next.ana_used = (active_next && s_next.hold_cnt == '0) ? local_analog_in
			: s_reg.sh_analog; // RL17
		s_next.spd_used = (active_next && s_next.hold_cnt == '0) ? local_speed_in
			: s_reg.sh_speed; // RL18
		s_next.virt_used = active_next ? local_virt_in : s_reg.sh_virt; // RL16
		s_next.excite = (active_next || !peer_ok) ? local_excite_in
			: s_reg.peer_excite; // RL19
		// Read data for the cycle after the read strobe.
		s_next.rdata = '0;
		if (rd_in) begin
			case (addr_in)
				ADDR_ROLE: s_next.rdata = {30'h0, s_reg.role};
				ADDR_CFG: s_next.rdata = {{(32-CFG_W){1'b0}}, s_reg.cfg};
				ADDR_KEY: s_next.rdata = {31'h0, s_reg.su_ok};
				ADDR_OPMODE: s_next.rdata = {31'h0, s_reg.local_off};
				ADDR_STATUS: s_next.rdata = {24'h0, s_reg.peer_role, peer_ok, s_reg.warn,
					s_reg.alarm, (s_reg.st == ST_BOOT), (s_reg.st == ST_ACTIVE), s_reg.relay};
				default: s_next.rdata = '0;
			endcase
		end
	end

	// State register; reset leaves the unit disabled, standby, flags clear.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_reg <= '0; // RL22
			s_reg.st <= ST_STANDBY;
			s_reg.cfg <= CFG_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdata_out = s_reg.rdata;
	assign peer_dtr_out = s_reg.dtr;
	assign msg_send_out = s_reg.msg_send;
	assign msg_role_out = s_reg.role;
	assign msg_active_out = s_reg.can_tx;
	assign msg_off_out = s_reg.local_off;
	assign msg_cfg_out = s_reg.cfg;
	assign msg_analog_out = s_reg.ana_used;
	assign msg_speed_out = s_reg.spd_used;
	assign msg_virt_out = s_reg.virt_used;
	assign msg_excite_out = s_reg.excite;
	assign transfer_relay_cmd_out = s_reg.relay;
	assign in_control_indicator_out = s_reg.indic;
	assign can_tx_en_out = s_reg.can_tx;
	assign wrong_config_alarm_out = s_reg.alarm;
	assign relay_failure_warning_out = s_reg.warn;
	assign analog_used_out = s_reg.ana_used;
	assign speed_used_out = s_reg.spd_used;
	assign virt_used_out = s_reg.virt_used;
	assign excite_out = s_reg.excite;

	// Checks on the supervisor behaviour.
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	property p_role_locked;
		wr_in && addr_in == ADDR_ROLE && !s_reg.su_ok |=> $stable(s_reg.role);
	endproperty
	a_role_locked: assert property (p_role_locked) // RL2
		else $error("role changed without super-user access");
	property p_same_role_alarm;
		same_role |=> wrong_config_alarm_out;
	endproperty
	a_same_role_alarm: assert property (p_same_role_alarm) // RL3
		else $error("same role did not raise the alarm");
	property p_same_role_no_relay;
		same_role && !(wr_in && addr_in == ADDR_ROLE)
			|=> !transfer_relay_cmd_out ##0 can_tx_en_out;
	endproperty
	a_same_role_no_relay: assert property (p_same_role_no_relay) // RL4
		else $error("relay driven or unit idle under same role");
	property p_missing_alarm;
		s_reg.role != ROLE_OFF && !s_reg.cfg[CFG_ASN_LO+FN_FEEDBACK] |=> wrong_config_alarm_out;
	endproperty
	a_missing_alarm: assert property (p_missing_alarm) // RL7
		else $error("missing assignment did not raise the alarm");
	property p_relay_backup;
		transfer_relay_cmd_out |-> s_reg.role == ROLE_BACKUP && can_tx_en_out;
	endproperty
	a_relay_backup: assert property (p_relay_backup) // RL9
		else $error("relay driven by a unit that is not the active backup");
	property p_indic_active;
		in_control_indicator_out |-> can_tx_en_out;
	endproperty
	a_indic_active: assert property (p_indic_active) // RL10 RL15
		else $error("indicator on while not active");
	property p_held_handover;
		handover_request_in && s_reg.ho_prev && s_reg.st == ST_ACTIVE
			&& s_reg.role == ROLE_BACKUP && !wr_in |=> s_reg.st == ST_ACTIVE;
	endproperty
	a_held_handover: assert property (p_held_handover) // RL11
		else $error("held handover level acted again");
	property p_reset_mode;
		ho_edge && s_reg.cfg[CFG_RSTMODE] && !s_reg.local_off && s_reg.st == ST_ACTIVE
			&& s_reg.role == ROLE_BACKUP && !wr_in |=> s_reg.st == ST_ACTIVE;
	endproperty
	a_reset_mode: assert property (p_reset_mode) // RL12
		else $error("handover accepted outside off mode");
	property p_warn_backup;
		relay_failure_warning_out |-> s_reg.role == ROLE_BACKUP;
	endproperty
	a_warn_backup: assert property (p_warn_backup) // RL14
		else $error("warning raised by a unit that is not backup");
	property p_dtr_period;
		$changed(peer_dtr_out) |-> $past(s_reg.dtr_cnt) == DTR_LAST;
	endproperty
	a_dtr_period: assert property (p_dtr_period) // RL20
		else $error("DTR toggled off period");
	property p_hold_shared;
		s_reg.hold_cnt > 2 && s_reg.st == ST_ACTIVE |=> analog_used_out == $past(s_reg.sh_analog);
	endproperty
	a_hold_shared: assert property (p_hold_shared) // RL17
		else $error("local analogue used during the hold");
	c_takeover: cover property (s_reg.st == ST_STANDBY && s_reg.role == ROLE_BACKUP
		##1 s_reg.st == ST_ACTIVE);
	c_handover: cover property (ho_allowed && s_reg.role == ROLE_MASTER
		&& s_reg.st == ST_STANDBY);
	c_alarm: cover property (same_role ##1 wrong_config_alarm_out);
	c_warn: cover property ($rose(relay_failure_warning_out));
endmodule
`default_nettype wire

// *** sim/hrs_peer_model.sv ***
// Behavioural peer controller that paces the link heartbeat and status messages.
`timescale 1ns/1ps
`default_nettype none
module hrs_peer_model #(
	parameter int DTR_CYC = 8,
	parameter int TX_CYC  = 20
) (
	input  wire logic mclk_in,
	input  wire logic rst_n_in,
	input  wire logic alive_in,
	output logic      dsr_out,
	output logic      msg_valid_out
);
	int dtr_cnt;
	int tx_cnt;
	// A dead peer freezes its heartbeat line and stops sending messages.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dtr_cnt <= 0;
			tx_cnt <= 0;
			dsr_out <= 1'b0;
			msg_valid_out <= 1'b0;
		end else begin
			msg_valid_out <= 1'b0;
			if (alive_in) begin
				dtr_cnt <= (dtr_cnt == DTR_CYC - 1) ? 0 : dtr_cnt + 1;
				tx_cnt <= (tx_cnt == TX_CYC - 1) ? 0 : tx_cnt + 1;
				if (dtr_cnt == DTR_CYC - 1) dsr_out <= !dsr_out;
				if (tx_cnt == TX_CYC - 1) msg_valid_out <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** sim/hot_redundancy_supervisor_tb.sv ***
// Self-checking testbench for the hot redundancy supervisor.
`timescale 1ns/1ps
`default_nettype none
module hot_redundancy_supervisor_tb;
	import hrs_pkg::*;
	logic        mclk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0, rd = 1'b0, ho = 1'b0, fb = 1'b0, alive = 1'b0;
	logic [1:0]  prole = 2'h2;
	logic        pact = 1'b1, poff = 1'b0, pexc = 1'b1, lexc = 1'b0;
	logic [8:0]  pcfg = 9'h01e;
	logic [15:0] pana = 16'h1234, pspd = 16'h0777, lana = 16'h0abc, lspd = 16'h0111;
	logic [7:0]  pvirt = 8'h5a, lvirt = 8'ha5;
	logic        dsr, pvalid;
	logic [31:0] rdata;
	logic        dtr, send, mact, moff, mexc, relay, indic, cantx, alarm, warn, exc;
	logic [1:0]  mrole;
	logic [8:0]  mcfg;
	logic [15:0] mana, mspd, aused, sused;
	logic [7:0]  mvirt, vused;
	int          err_total = 0;
	int          num_checks = 0;

	hrs_peer_model #(.DTR_CYC(8), .TX_CYC(20)) u_hrs_peer_model (.mclk_in(mclk_in),
		.rst_n_in(rst_n_in), .alive_in(alive), .dsr_out(dsr), .msg_valid_out(pvalid));

	hot_redundancy_supervisor #(.DTR_CYCLES(8), .TX_CYCLES(20), .RXTO_CYCLES(50),
		.DSRTO_CYCLES(30), .HOLD_CYCLES(16), .BOOTM_CYCLES(40), .BOOTB_CYCLES(80))
	u_hot_redundancy_supervisor (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.handover_request_in(ho), .transfer_relay_feedback_in(fb), .peer_dsr_in(dsr),
		.peer_msg_valid_in(pvalid), .peer_role_in(prole), .peer_active_in(pact),
		.peer_off_in(poff), .peer_cfg_in(pcfg), .peer_analog_in(pana),
		.peer_speed_in(pspd), .peer_virt_in(pvirt), .peer_excite_in(pexc),
		.local_analog_in(lana), .local_speed_in(lspd), .local_virt_in(lvirt),
		.local_excite_in(lexc), .peer_dtr_out(dtr), .msg_send_out(send),
		.msg_role_out(mrole), .msg_active_out(mact), .msg_off_out(moff),
		.msg_cfg_out(mcfg), .msg_analog_out(mana), .msg_speed_out(mspd),
		.msg_virt_out(mvirt), .msg_excite_out(mexc), .transfer_relay_cmd_out(relay),
		.in_control_indicator_out(indic), .can_tx_en_out(cantx),
		.wrong_config_alarm_out(alarm), .relay_failure_warning_out(warn),
		.analog_used_out(aused), .speed_used_out(sused), .virt_used_out(vused),
		.excite_out(exc));

	// Free-running 100 MHz clock.
	always #5 mclk_in = ~mclk_in;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask

	// One-cycle write strobe, released at the following edge.
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk_in);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic wait_tx(input logic v);
		for (int i = 0; i < 200 && cantx !== v; i++) tick(1);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic t_reset;
		repeat (20) @(posedge mclk_in);
		chk(cantx, 0);
		chk(alarm, 0);
		rst_n_in <= 1'b1;
		tick(3);
		chk(cantx, 1);
		chk(relay, 0);
		rd_reg(ADDR_ROLE, 0);
		rd_reg(ADDR_KEY, 0);
		rd_reg(8'h20, 0);
		$display("reset test done");
	endtask

	task automatic t_key;
		wr_reg(ADDR_ROLE, 1);
		rd_reg(ADDR_ROLE, 0);
		wr_reg(ADDR_KEY, SU_KEY);
		rd_reg(ADDR_KEY, 1);
		wr_reg(ADDR_ROLE, 3);
		rd_reg(ADDR_ROLE, 0);
		wr_reg(ADDR_KEY, 32'h1);
		wr_reg(ADDR_ROLE, 2);
		rd_reg(ADDR_ROLE, 0);
		$display("key test done");
	endtask

	// Backup with a silent peer; missing or expansion-mapped functions alarm.
	task automatic t_cfg;
		wr_reg(ADDR_KEY, SU_KEY);
		wr_reg(ADDR_ROLE, 1);
		tick(4);
		chk(alarm, 1);
		wr_reg(ADDR_CFG, 32'h03e);
		tick(4);
		chk(alarm, 1);
		wr_reg(ADDR_CFG, 32'h01e);
		tick(4);
		chk(alarm, 0);
		$display("config test done");
	endtask

	task automatic t_takeover;
		wr_reg(ADDR_CFG, 32'h0);
		alive <= 1'b1;
		tick(120);
		chk(cantx, 0);
		chk(relay, 0);
		chk(indic, 0);
		chk(alarm, 0);
		rd_reg(ADDR_CFG, 32'h01e);
		rd_reg(ADDR_ROLE, 1);
		chk(vused, 8'h5a);
		chk(exc, 1);
		@(posedge mclk_in);
		fb <= 1'b1;
		tick(4);
		chk(warn, 1);
		@(posedge mclk_in);
		fb <= 1'b0;
		tick(4);
		chk(warn, 0);
		@(posedge mclk_in);
		alive <= 1'b0;
		fb <= 1'b1;
		wait_tx(1);
		chk(cantx, 1);
		chk(relay, 1);
		chk(indic, 1);
		chk(aused, 16'h1234);
		chk(sused, 16'h0777);
		tick(8);
		chk(aused, 16'h1234);
		tick(16);
		chk(aused, 16'h0abc);
		chk(sused, 16'h0111);
		chk(warn, 0);
		// Active unit follows its own inputs once the hold is over.
		@(posedge mclk_in);
		lana <= 16'h0bcd;
		lspd <= 16'h0222;
		lvirt <= 8'h3c;
		lexc <= 1'b1;
		tick(2);
		chk(aused, 16'h0bcd);
		chk(sused, 16'h0222);
		chk(vused, 8'h3c);
		chk(exc, 1);
		$display("takeover test done");
	endtask

	task automatic t_handover;
		@(posedge mclk_in);
		pcfg <= 9'h01f;
		pexc <= 1'b0;
		pvirt <= 8'hc3;
		pana <= 16'h4321;
		pspd <= 16'h0888;
		pact <= 1'b0;
		poff <= 1'b1;
		alive <= 1'b1;
		tick(60);
		@(posedge mclk_in);
		ho <= 1'b1;
		tick(4);
		chk(cantx, 1);
		@(posedge mclk_in);
		ho <= 1'b0;
		wr_reg(ADDR_OPMODE, 1);
		tick(2);
		@(posedge mclk_in);
		ho <= 1'b1;
		tick(3);
		chk(cantx, 0);
		chk(relay, 0);
		chk(vused, 8'hc3);
		chk(exc, 0);
		chk(aused, 16'h4321);
		chk(sused, 16'h0888);
		tick(10);
		chk(cantx, 0);
		@(posedge mclk_in);
		ho <= 1'b0;
		$display("handover test done");
	endtask

	// Peer claims the backup role as well: both run, relay stays off.
	task automatic t_same_role;
		prole <= 2'h1;
		pact <= 1'b1;
		for (int i = 0; i < 100 && alarm !== 1'b1; i++) tick(1);
		chk(alarm, 1);
		wait_tx(1);
		chk(cantx, 1);
		chk(relay, 0);
		$display("same role test done");
	endtask

	task automatic t_master;
		logic d;
		// Let the peer time out first, so the master boot wait is not cut short.
		@(posedge mclk_in);
		alive <= 1'b0;
		tick(40);
		chk(alarm, 0);
		chk(relay, 1);
		wr_reg(ADDR_ROLE, 2);
		tick(20);
		chk(cantx, 0);
		wait_tx(1);
		chk(cantx, 1);
		chk(relay, 0);
		d = dtr;
		tick(8);
		chk(dtr, !d);
		for (int i = 0; i < 30 && send !== 1'b1; i++) tick(1);
		chk(send, 1);
		chk(mrole, 2);
		chk(mcfg, 9'h01f);
		$display("master test done");
	endtask

	// Main sequence.
	initial begin
		t_reset();
		t_key();
		t_cfg();
		t_takeover();
		t_handover();
		t_same_role();
		t_master();
		wrap_up();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		#50000;
		err_total++;
		$display("wrong value at %0t: watchdog expired", $time);
		wrap_up();
	end
endmodule
`default_nettype wire
